//--- hw/csef_pkg.sv
// Package: register map, field positions, reset values and carriers for the socket event flag block
package csef_pkg;

  // Documented register offsets (byte addresses on the register port)
  localparam logic [7:0] CSEF_OFS_CARD_EVENT_FLAGS = 8'h04;
  localparam logic [7:0] CSEF_OFS_CARD_EVENT_MASK = 8'h05;
  localparam logic [7:0] CSEF_OFS_LEGACY_GLOBAL_CONTROL = 8'h1e;
  localparam logic [7:0] CSEF_OFS_CARD_CONTROL = 8'h91;
  // Socket register set for wide cards, placed in otherwise free offsets
  localparam logic [7:0] CSEF_OFS_SOCKET_EVENT = 8'hc0;
  localparam logic [7:0] CSEF_OFS_SOCKET_MASK = 8'hc4;
  localparam logic [7:0] CSEF_OFS_SOCKET_STATE = 8'hc8;
  localparam logic [7:0] CSEF_OFS_SOCKET_FORCE = 8'hcc;

  // Event field widths and bit positions
  localparam int CSEF_EVT_W = 4;
  localparam int CSEF_BIT_BATT_ONE = 0;
  localparam int CSEF_BIT_IO_IO_STATUS_CHANGE = 0;
  localparam int CSEF_BIT_BATT_TWO = 1;
  localparam int CSEF_BIT_READY = 2;
  localparam int CSEF_BIT_PWR_DONE = 3;
  localparam int CSEF_BIT_WIDE_IO_STATUS_CHANGE = 0;
  localparam int CSEF_BIT_DETECT_ONE = 1;
  localparam int CSEF_BIT_DETECT_TWO = 2;
  localparam int CSEF_BIT_CLEAR_METHOD = 2;
  localparam int CSEF_BIT_FUNC_PENDING = 0;

  // Reset values
  localparam logic [7:0] CSEF_RST_MASK = 8'h00;
  localparam logic [7:0] CSEF_RST_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] CSEF_RST_CARD_CONTROL = 8'h00;
  localparam logic [7:0] CSEF_RST_RD_DATA = 8'h00;

  // Cycles after reset before a synchronised pin is trusted for edge detection
  localparam logic [1:0] CSEF_ARM_CYCLES = 2'h3;

  // Socket pin indices into the watched pin vector
  localparam int CSEF_PIN_DETECT_ONE = 0;
  localparam int CSEF_PIN_DETECT_TWO = 1;
  localparam int CSEF_PIN_SHARED_ONE = 2;
  localparam int CSEF_PIN_SHARED_TWO = 3;
  localparam int CSEF_PIN_READY_IRQ = 4;
  localparam int CSEF_PIN_N = 5;

  // Kind of card sitting in the socket
  typedef enum logic [1:0] {
    CSEF_CARD_NONE,
    CSEF_CARD_MEM,
    CSEF_CARD_IO,
    CSEF_CARD_WIDE
  } csef_card_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csef_reg_req_t;

  // Raw socket pins, all asynchronous to clk_i
  typedef struct packed {
    logic card_detect_one_n;
    logic card_detect_two_n;
    logic shared_one;
    logic shared_two;
    logic ready_irq;
  } csef_pins_t;

endpackage

//--- hw/csef_pin_watch.sv
// One socket pin: two-flop synchroniser, armed edge detector
module csef_pin_watch
  import csef_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pin
  input wire logic pin_i,
  // Synchronised level and one-cycle edge pulses
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta;
  logic sync;
  logic prev;
  logic [1:0] arm_cnt;
  logic next_meta;
  logic next_sync;
  logic next_prev;
  logic [1:0] next_arm_cnt;

  // Next values; edges are suppressed until the chain holds real pin values
  always_comb begin
    next_meta = pin_i;
    next_sync = meta;
    next_prev = sync;
    next_arm_cnt = (arm_cnt == CSEF_ARM_CYCLES) ? arm_cnt : arm_cnt + 2'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      arm_cnt <= 2'h0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
      arm_cnt <= next_arm_cnt;
    end
  end

  // Edge pulses come from the second and third stages only
  assign level_o = sync;
  assign rise_o = (arm_cnt == CSEF_ARM_CYCLES) && sync && !prev;
  assign fall_o = (arm_cnt == CSEF_ARM_CYCLES) && !sync && prev;

endmodule

//--- hw/csef_flag_bank.sv
// Sticky flag bank: hardware set beats software clear in the same cycle
module csef_flag_bank #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Set and clear strobes per bit
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // Flags
  output logic [W-1:0] flags_o
);

  logic [W-1:0] flags;
  logic [W-1:0] next_flags;

  // Clear first, then set, so a coincident event survives
  always_comb begin
    next_flags = (flags & ~clr_i) | set_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  assign flags_o = flags;

endmodule

//--- hw/csef_top.sv
// Card socket event flags: event detection, masking, flag clearing and request outputs
module csef_top
  import csef_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire csef_reg_req_t reg_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Socket pins and socket state
  input wire csef_pins_t pins_i,
  input wire csef_card_t card_type_i,
  input wire logic power_up_done_i,
  // Requests to the interrupt routing logic
  output logic csc_irq_o,
  output logic func_irq_o
);

  // Synchronised socket pins and their edges
  logic [CSEF_PIN_N-1:0] pin_raw;
  logic [CSEF_PIN_N-1:0] pin_level;
  logic [CSEF_PIN_N-1:0] pin_rise;
  logic [CSEF_PIN_N-1:0] pin_fall;
  logic [CSEF_PIN_N-1:0] pin_edge;

  // Card type decode
  logic is_mem;
  logic is_io;
  logic is_wide;

  // Register decode
  logic wr_flags;
  logic rd_flags;
  logic wr_mask;
  logic wr_global;
  logic wr_control;
  logic wr_sock_event;
  logic wr_sock_mask;
  logic wr_sock_force;

  // Software-visible state
  logic [7:0] card_event_mask;
  logic [7:0] legacy_global_control;
  logic [7:0] card_control;
  logic [CSEF_EVT_W-1:0] socket_mask;
  logic [7:0] next_card_event_mask;
  logic [7:0] next_legacy_global_control;
  logic [7:0] next_card_control;
  logic [CSEF_EVT_W-1:0] next_socket_mask;

  // Flag banks
  logic [CSEF_EVT_W-1:0] narrow_set;
  logic [CSEF_EVT_W-1:0] narrow_clr;
  logic [CSEF_EVT_W-1:0] narrow_flags;
  logic [CSEF_EVT_W-1:0] sock_set;
  logic [CSEF_EVT_W-1:0] sock_clr;
  logic [CSEF_EVT_W-1:0] sock_flags;

  // Decoded socket signals
  logic io_status_change_assert;
  logic wide_card_status_change_assert;
  logic func_request;
  logic clear_on_write;

  // Outputs
  logic [7:0] rd_data;
  logic rd_valid;
  logic csc_irq;
  logic func_irq;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic next_csc_irq;
  logic next_func_irq;

  // Pin vector in watch order
  assign pin_raw[CSEF_PIN_DETECT_ONE] = pins_i.card_detect_one_n;
  assign pin_raw[CSEF_PIN_DETECT_TWO] = pins_i.card_detect_two_n;
  assign pin_raw[CSEF_PIN_SHARED_ONE] = pins_i.shared_one;
  assign pin_raw[CSEF_PIN_SHARED_TWO] = pins_i.shared_two;
  assign pin_raw[CSEF_PIN_READY_IRQ] = pins_i.ready_irq;

  // One synchroniser and edge detector per socket pin
  for (genvar gi = 0; gi < CSEF_PIN_N; gi++) begin : g_pin
    csef_pin_watch u_watch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(pin_raw[gi]),
      .level_o(pin_level[gi]),
      .rise_o(pin_rise[gi]),
      .fall_o(pin_fall[gi])
    );
  end

  assign pin_edge = pin_rise | pin_fall;

  // Card type decode steers how the shared pins are read
  assign is_mem = (card_type_i == CSEF_CARD_MEM);
  assign is_io = (card_type_i == CSEF_CARD_IO);
  assign is_wide = (card_type_i == CSEF_CARD_WIDE);

  // Shared pin one: battery detect one, io status change (low), wide status change (high)
  assign io_status_change_assert = is_io && pin_fall[CSEF_PIN_SHARED_ONE];
  assign wide_card_status_change_assert = is_wide && pin_rise[CSEF_PIN_SHARED_ONE];

  // Ready pin carries an active-low request for io and wide cards, never for memory cards
  assign func_request = (is_io || is_wide) && !pin_level[CSEF_PIN_READY_IRQ];

  // Register strobes at the documented offsets and at the socket register set offsets
  assign wr_flags = reg_req_i.wr && (reg_req_i.addr == CSEF_OFS_CARD_EVENT_FLAGS);
  assign rd_flags = reg_req_i.rd && (reg_req_i.addr == CSEF_OFS_CARD_EVENT_FLAGS);
  assign wr_mask = reg_req_i.wr && (reg_req_i.addr == CSEF_OFS_CARD_EVENT_MASK);
  assign wr_global = reg_req_i.wr && (reg_req_i.addr == CSEF_OFS_LEGACY_GLOBAL_CONTROL);
  assign wr_control = reg_req_i.wr && (reg_req_i.addr == CSEF_OFS_CARD_CONTROL);
  assign wr_sock_event = reg_req_i.wr && (reg_req_i.addr == CSEF_OFS_SOCKET_EVENT);
  assign wr_sock_mask = reg_req_i.wr && (reg_req_i.addr == CSEF_OFS_SOCKET_MASK);
  assign wr_sock_force = reg_req_i.wr && (reg_req_i.addr == CSEF_OFS_SOCKET_FORCE);

  // Clearing method for the narrow card flags
  assign clear_on_write = legacy_global_control[CSEF_BIT_CLEAR_METHOD];

  // Narrow card flag sources
  always_comb begin
    narrow_set = '0;
    narrow_set[CSEF_BIT_BATT_ONE] = (is_mem && pin_edge[CSEF_PIN_SHARED_ONE])
      || io_status_change_assert;
    narrow_set[CSEF_BIT_BATT_TWO] = is_mem && pin_edge[CSEF_PIN_SHARED_TWO];
    narrow_set[CSEF_BIT_READY] = is_mem && pin_edge[CSEF_PIN_READY_IRQ];
    narrow_set[CSEF_BIT_PWR_DONE] = (is_mem || is_io) && power_up_done_i;
  end

  // Narrow card flag clearing: write of one or read, chosen by the method bit
  always_comb begin
    narrow_clr = '0;
    if (clear_on_write) begin
      if (wr_flags) begin
        narrow_clr = reg_req_i.wdata[CSEF_EVT_W-1:0];
      end
    end else if (rd_flags) begin
      narrow_clr = '1;
    end
  end

  // Socket event sources; detect edges count for every card type
  always_comb begin
    sock_set = '0;
    sock_set[CSEF_BIT_WIDE_IO_STATUS_CHANGE] = wide_card_status_change_assert;
    sock_set[CSEF_BIT_DETECT_ONE] = pin_edge[CSEF_PIN_DETECT_ONE];
    sock_set[CSEF_BIT_DETECT_TWO] = pin_edge[CSEF_PIN_DETECT_TWO];
    sock_set[CSEF_BIT_PWR_DONE] = is_wide && power_up_done_i;
    if (wr_sock_force) begin
      sock_set = sock_set | reg_req_i.wdata[CSEF_EVT_W-1:0];
    end
  end

  // Socket events clear on a write of one
  assign sock_clr = wr_sock_event ? reg_req_i.wdata[CSEF_EVT_W-1:0] : '0;

  csef_flag_bank #(
    .W(CSEF_EVT_W)
  ) u_narrow_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(narrow_set),
    .clr_i(narrow_clr),
    .flags_o(narrow_flags)
  );

  csef_flag_bank #(
    .W(CSEF_EVT_W)
  ) u_socket_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(sock_set),
    .clr_i(sock_clr),
    .flags_o(sock_flags)
  );

  // Control register next values; card control bit 0 is live status, not storage
  always_comb begin
    next_card_event_mask = card_event_mask;
    next_legacy_global_control = legacy_global_control;
    next_card_control = card_control;
    next_socket_mask = socket_mask;
    if (wr_mask) begin
      next_card_event_mask = reg_req_i.wdata;
    end
    if (wr_global) begin
      next_legacy_global_control = reg_req_i.wdata;
    end
    if (wr_control) begin
      next_card_control = reg_req_i.wdata;
    end
    next_card_control[CSEF_BIT_FUNC_PENDING] = 1'b0;
    if (wr_sock_mask) begin
      next_socket_mask = reg_req_i.wdata[CSEF_EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_event_mask <= CSEF_RST_MASK;
      legacy_global_control <= CSEF_RST_GLOBAL_CONTROL;
      card_control <= CSEF_RST_CARD_CONTROL;
      socket_mask <= CSEF_RST_MASK[CSEF_EVT_W-1:0];
    end else begin
      card_event_mask <= next_card_event_mask;
      legacy_global_control <= next_legacy_global_control;
      card_control <= next_card_control;
      socket_mask <= next_socket_mask;
    end
  end

  // Read mux, answered one cycle after the read strobe; unmapped offsets read zero
  always_comb begin
    next_rd_data = CSEF_RST_RD_DATA;
    next_rd_valid = reg_req_i.rd;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        CSEF_OFS_CARD_EVENT_FLAGS: begin
          next_rd_data = {4'h0, narrow_flags};
        end
        CSEF_OFS_CARD_EVENT_MASK: begin
          next_rd_data = card_event_mask;
        end
        CSEF_OFS_LEGACY_GLOBAL_CONTROL: begin
          next_rd_data = legacy_global_control;
        end
        CSEF_OFS_CARD_CONTROL: begin
          next_rd_data = {card_control[7:1], func_irq};
        end
        CSEF_OFS_SOCKET_EVENT: begin
          next_rd_data = {4'h0, sock_flags};
        end
        CSEF_OFS_SOCKET_MASK: begin
          next_rd_data = {4'h0, socket_mask};
        end
        CSEF_OFS_SOCKET_STATE: begin
          next_rd_data = {1'b0, card_type_i, pin_level};
        end
        default: begin
          next_rd_data = CSEF_RST_RD_DATA;
        end
      endcase
    end
  end

  // Two separate requests: masked status change, unmasked functional
  always_comb begin
    next_csc_irq = |(narrow_flags & card_event_mask[CSEF_EVT_W-1:0])
      || |(sock_flags & socket_mask);
    next_func_irq = func_request;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data <= CSEF_RST_RD_DATA;
      rd_valid <= 1'b0;
      csc_irq <= 1'b0;
      func_irq <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      csc_irq <= next_csc_irq;
      func_irq <= next_func_irq;
    end
  end

  assign rd_data_o = rd_data;
  assign rd_valid_o = rd_valid;
  assign csc_irq_o = csc_irq;
  assign func_irq_o = func_irq;

endmodule

//--- bench/csef_properties.sv
// Checker: timing and masking properties of the socket event flag block
module csef_properties
  import csef_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire csef_reg_req_t reg_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  // Socket side
  input wire csef_pins_t pins_i,
  input wire csef_card_t card_type_i,
  input wire logic power_up_done_i,
  // Requests
  input wire logic csc_irq_o,
  input wire logic func_irq_o
);
  logic [3:0] nmask;
  logic [3:0] smask;
  logic [2:0] arm;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Shadow of both mask registers and a settle counter after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmask <= 4'h0;
      smask <= 4'h0;
      arm <= 3'h0;
    end else begin
      if (reg_req_i.wr && reg_req_i.addr == CSEF_OFS_CARD_EVENT_MASK) nmask <= reg_req_i.wdata[3:0];
      if (reg_req_i.wr && reg_req_i.addr == CSEF_OFS_SOCKET_MASK) smask <= reg_req_i.wdata[3:0];
      if (arm != 3'h7) arm <= arm + 3'h1;
    end
  end

  // Request line held low by a card that may raise functional requests
  sequence s_req_low_held;
    (card_type_i inside {CSEF_CARD_IO, CSEF_CARD_WIDE} && !pins_i.ready_irq) [*4];
  endsequence

  // Detect line change with its socket mask bit enabled, pins armed
  sequence s_detect_change;
    arm == 3'h7 && smask[CSEF_BIT_DETECT_ONE] && $changed(pins_i.card_detect_one_n);
  endsequence

  a_read_answer: assert property (reg_req_i.rd |=> rd_valid_o)
    else $error("read got no answer");
  a_no_stray_answer: assert property (!reg_req_i.rd |=> !rd_valid_o && rd_data_o == 8'h00)
    else $error("answer without a read");
  a_mem_no_func: assert property ((card_type_i == CSEF_CARD_MEM) [*2] |-> !func_irq_o)
    else $error("functional request from memory card");
  a_func_type_gate: assert property (func_irq_o |-> $past(card_type_i) inside {CSEF_CARD_IO, CSEF_CARD_WIDE})
    else $error("functional request for wrong card type");
  a_func_pass: assert property (s_req_low_held |-> func_irq_o)
    else $error("functional request not passed");
  a_func_drop: assert property (pins_i.ready_irq [*4] |-> !func_irq_o)
    else $error("functional request without pin");
  a_masked_quiet: assert property ((nmask == 4'h0 && smask == 4'h0) [*2] |-> !csc_irq_o)
    else $error("status request with all masks off");
  a_insert_raise: assert property (s_detect_change |-> ##4 csc_irq_o)
    else $error("insertion gave no status request");
endmodule

bind csef_top csef_properties csef_properties_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .reg_req_i(reg_req_i),
  .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o),
  .pins_i(pins_i),
  .card_type_i(card_type_i),
  .power_up_done_i(power_up_done_i),
  .csc_irq_o(csc_irq_o),
  .func_irq_o(func_irq_o)
);

//--- bench/csef_card_model.sv
// Card model: holds the socket pin levels that a card drives
module csef_card_model
  import csef_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Socket pins towards the block
  output csef_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CSEF_PIN_N-1:0] lvl = 5'h1f;

  // Shared pins carry battery or status by card kind; the ready pin carries ready or request
  assign pins_o = {lvl[0], lvl[1], lvl[2], lvl[3], lvl[4]};

  // Change one pin just after a clock edge
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk_i);
    lvl[idx] <= v;
  endtask
endmodule

//--- bench/testbench.sv
// Testbench: register tasks and socket scenarios for the event flag block
module testbench
  import csef_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  csef_reg_req_t reg_req_i = '0;
  csef_card_t card_type_i = CSEF_CARD_NONE;
  logic power_up_done_i = 1'b0;
  csef_pins_t pins_i;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic csc_irq_o;
  logic func_irq_o;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] rst_addr [6] = '{8'h04, 8'h05, 8'h1e, 8'h91, 8'hc0, 8'h33};

  // Clock
  always #5 clk_i = ~clk_i;

  // Card and block under test
  csef_card_model csef_card_model_inst (.clk_i(clk_i), .pins_o(pins_i));
  csef_top csef_top_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reg_req_i(reg_req_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .pins_i(pins_i),
    .card_type_i(card_type_i),
    .power_up_done_i(power_up_done_i),
    .csc_irq_o(csc_irq_o),
    .func_irq_o(func_irq_o)
  );

  // Compare tasks
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected data at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected bit at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Register port cycles
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_req_i.wr <= 1'b1;
    reg_req_i.addr <= a;
    reg_req_i.wdata <= d;
    @(posedge clk_i);
    reg_req_i.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_req_i.rd <= 1'b1;
    reg_req_i.addr <= a;
    @(posedge clk_i);
    reg_req_i.rd <= 1'b0;
    #1;
    chk_bit(rd_valid_o, 1'b1);
    chk_data(rd_data_o, exp);
  endtask

  // Helpers for waiting, power completion, pins and test ends
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse_power();
    @(posedge clk_i);
    power_up_done_i <= 1'b1;
    @(posedge clk_i);
    power_up_done_i <= 1'b0;
  endtask
  task automatic pin(input int idx, input logic v);
    csef_card_model_inst.set_pin(idx, v);
  endtask
  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask

  // Report and end the run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  // Scenarios
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_cyc(6);
    reg_wr(8'h33, 8'hff);
    foreach (rst_addr[i]) reg_rd(rst_addr[i], 8'h00);
    end_test("reset");
    card_type_i <= CSEF_CARD_MEM;
    pin(CSEF_PIN_SHARED_ONE, 1'b0);
    pin(CSEF_PIN_SHARED_TWO, 1'b0);
    pin(CSEF_PIN_READY_IRQ, 1'b0);
    wait_cyc(5);
    chk_bit(csc_irq_o, 1'b0);
    chk_bit(func_irq_o, 1'b0);
    reg_rd(8'h04, 8'h07);
    reg_rd(8'h04, 8'h00);
    reg_wr(8'h05, 8'h04);
    pin(CSEF_PIN_READY_IRQ, 1'b1);
    wait_cyc(5);
    chk_bit(csc_irq_o, 1'b1);
    reg_rd(8'h04, 8'h04);
    wait_cyc(2);
    chk_bit(csc_irq_o, 1'b0);
    end_test("memory");
    reg_wr(8'h1e, 8'h04);
    pin(CSEF_PIN_SHARED_ONE, 1'b1);
    pin(CSEF_PIN_SHARED_TWO, 1'b1);
    wait_cyc(5);
    reg_rd(8'h04, 8'h03);
    reg_rd(8'h04, 8'h03);
    reg_wr(8'h04, 8'h01);
    reg_rd(8'h04, 8'h02);
    reg_wr(8'h04, 8'h02);
    reg_rd(8'h04, 8'h00);
    end_test("write_clear");
    card_type_i <= CSEF_CARD_IO;
    pin(CSEF_PIN_SHARED_ONE, 1'b0);
    pin(CSEF_PIN_READY_IRQ, 1'b0);
    pulse_power();
    wait_cyc(5);
    chk_bit(func_irq_o, 1'b1);
    chk_bit(csc_irq_o, 1'b0);
    reg_rd(8'h91, 8'h01);
    reg_rd(8'h04, 8'h09);
    reg_wr(8'h04, 8'h09);
    pin(CSEF_PIN_READY_IRQ, 1'b1);
    wait_cyc(5);
    chk_bit(func_irq_o, 1'b0);
    reg_rd(8'h04, 8'h00);
    end_test("io");
    reg_wr(8'hc4, 8'h0f);
    card_type_i <= CSEF_CARD_NONE;
    pin(CSEF_PIN_DETECT_ONE, 1'b0);
    wait_cyc(5);
    card_type_i <= CSEF_CARD_WIDE; // Narrow registers left alone from here
    pin(CSEF_PIN_SHARED_ONE, 1'b1);
    pin(CSEF_PIN_DETECT_TWO, 1'b0);
    pulse_power();
    pin(CSEF_PIN_READY_IRQ, 1'b0);
    wait_cyc(5);
    chk_bit(csc_irq_o, 1'b1);
    chk_bit(func_irq_o, 1'b1);
    reg_rd(8'hc0, 8'h0f);
    reg_wr(8'hc0, 8'h05);
    reg_rd(8'hc0, 8'h0a);
    reg_wr(8'hc0, 8'h0a);
    reg_rd(8'hc0, 8'h00);
    reg_wr(8'hcc, 8'h08);
    reg_rd(8'hc0, 8'h08);
    reg_wr(8'hc0, 8'h08);
    reg_rd(8'hc4, 8'h0f);
    pin(CSEF_PIN_READY_IRQ, 1'b1);
    wait_cyc(5);
    chk_bit(csc_irq_o, 1'b0);
    chk_bit(func_irq_o, 1'b0);
    reg_rd(8'hc8, 8'h7c);
    end_test("wide");
    // Reset in mid-run with pins away from their reset levels: no false events
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_cyc(6);
    chk_bit(csc_irq_o, 1'b0);
    reg_rd(8'h1e, 8'h00);
    reg_rd(8'h05, 8'h00);
    reg_rd(8'hc0, 8'h00);
    reg_rd(8'h04, 8'h00);
    end_test("mid_reset");
    finish_test();
  end
endmodule
